/* File: src/bcs_sequencer.sv */
// Purpose: charge cycle state machine with timers, drain latch and registers
// Assumes: analog comparators deliver levels; straps are static
// Notes:   indicator blink patterns and analog loop live outside this block
`timescale 1ns/100ps
// How it works
// - mode strap picks amplifier or switched comparator
// - pack present or inserted starts a cycle
// - conditioning at low rate until 1V
// - bulk ends on overheat or pack removal
// - slope over 0.5C/min moves to finishing
// - backup timer 30min..6h ends bulk
// - finishing lasts half or quarter span
// - done holds until removal, discharge or suspend
// - discharge disables charging, transistor fully on
// - drain latch sets at detect level
// - drain latch clears at release level
// - low setpoint in conditioning and finishing
// - open-drain indicator shows charge status
// - slope ignored first 4.3 minutes
// - conditioning over 30 minutes faults
// - leaving await needs 0..45C window
// - drain release returns to await
module bcs_sequencer
	import bcs_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = SEC_CYCLES   // shorten in simulation
) (
	input  wire logic        clock_i,
	input  wire logic        sys_rst_i,
	// comparator flags from the analog front end
	input  wire logic        cell_in_i,           // below detect level
	input  wire logic        cell_open_i,         // above open level
	input  wire logic        cell_above_low_i,    // above low_cell_level
	input  wire logic        temp_ok_i,           // thermistor_sense in window
	input  wire logic        temp_hot_i,          // thermistor_sense over 50 C
	input  wire logic        slope_high_i,        // slope over limit
	input  wire logic        drain_set_i,         // drain_detect_level reached
	input  wire logic        drain_release_i,     // drain_release_level reached
	input  wire logic        current_low_i,       // sense below setpoint
	input  wire logic        linear_mode_i,       // strap: 1 amplifier, 0 comparator
	input  wire logic        quarter_variant_i,   // strap: finishing is a quarter
	input  wire logic [3:0]  timeout_select_i,    // span code from resistor
	// charge control
	output logic             charge_drive_out_o,  // pin level when enabled, always 0
	output logic             charge_drive_oe_o,   // pulls regulating transistor on
	output logic             amp_enable_o,        // linear error amplifier active
	output logic             hysteresis_en_o,     // low_rate_hysteresis applied
	output logic             low_rate_o,          // low_rate_setpoint chosen
	output logic             charge_indicator_out_o,
	output logic             charge_indicator_oe_o,
	output logic             irq_o,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o
);
	// two-stage synchronisers, first stage read only by the second
	logic [F_W-1:0] flag_raw;                  // pin levels gathered
	logic [F_W-1:0] sync1_r;                   // first stage
	logic [F_W-1:0] flag_r;                    // second stage, used by logic
	logic [5:0]     strap1_r;                  // straps first stage
	logic [5:0]     strap_r;                   // straps second stage
	assign flag_raw = {current_low_i, drain_release_i, drain_set_i, slope_high_i,
		temp_hot_i, temp_ok_i, cell_above_low_i, cell_open_i, cell_in_i};

	// one synchroniser per comparator flag
	genvar gi;
	generate
		for (gi = 0; gi < F_W; gi++) begin : g_sync
			always_ff @(posedge clock_i) begin
				if (sys_rst_i) begin
					sync1_r[gi] <= 1'b0;
					flag_r[gi]  <= 1'b0;
				end else begin
					sync1_r[gi] <= flag_raw[gi];
					flag_r[gi]  <= sync1_r[gi];
				end
			end
		end
	endgenerate

	// strap sampling, straps are static so two stages suffice
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			strap1_r <= 6'h00;
			strap_r  <= 6'h00;
		end else begin
			strap1_r <= {linear_mode_i, quarter_variant_i, timeout_select_i};
			strap_r  <= strap1_r;
		end
	end

	logic       lin_mode;                      // amplifier style chosen
	logic       quarter;                       // alternate finishing ratio
	logic [3:0] span_code;                     // clamped timeout code
	assign lin_mode  = strap_r[5];
	assign quarter   = strap_r[4];
	assign span_code = (strap_r[3:0] > SPAN_CODE_MAX) ? SPAN_CODE_MAX : strap_r[3:0];

	// timeout spans in seconds
	logic [15:0] bulk_span_s;                  // selected bulk span
	logic [15:0] finish_span_s;                // finishing span
	assign bulk_span_s   = 16'(({12'h000, span_code} + 16'h0001) * BULK_UNIT_S);
	assign finish_span_s = quarter ? (bulk_span_s >> 2) : (bulk_span_s >> 1);

	// registers and state
	bcs_state_t      state_r, state_nxt;       // sequence state
	logic [31:0]     tick_cnt_r, tick_cnt_nxt; // prescaler to seconds
	logic [15:0]     sec_r, sec_nxt;           // seconds spent in state
	logic            drain_r, drain_nxt;       // discharge latch
	logic [31:0]     ctrl_r, ctrl_nxt;         // control register
	logic [EV_W-1:0] ist_r, ist_nxt;           // sticky events
	logic [EV_W-1:0] imk_r, imk_nxt;           // event mask
	logic            ack_r, ack_nxt;           // bus answer
	logic [31:0]     rdat_r, rdat_nxt;         // read data
	logic            sec_tick;                 // one-second strobe
	logic            wr_acc;                   // write at the acking edge
	logic [EV_W-1:0] ev;                       // events this cycle
	logic            enable;                   // software charge enable

	assign sec_tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
	assign enable   = ctrl_r[0];
	assign wr_acc   = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;

	// drain latch next value, set wins over release
	always_comb begin
		drain_nxt = drain_r;
		if (flag_r[F_DRAIN_SET]) begin
			drain_nxt = 1'b1;
		end else if (flag_r[F_DRAIN_REL]) begin
			drain_nxt = 1'b0;
		end
	end

	// sequence next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_AWAIT: begin
				// power-up with pack fitted looks the same as an insertion
				if (flag_r[F_CELL_IN] && flag_r[F_TEMP_OK]) begin
					state_nxt = ST_COND;
				end
			end
			ST_COND: begin
				// open ignored briefly: insertion bounce looks like removal
				if (flag_r[F_OPEN] && sec_r >= FILTER_SEC) begin
					state_nxt = ST_AWAIT;
				end else if (flag_r[F_TEMP_HOT] || sec_r >= COND_TMO_S) begin
					state_nxt = ST_FAULT;
				end else if (flag_r[F_ABOVE_LOW]) begin
					state_nxt = ST_BULK;
				end
			end
			ST_BULK: begin
				if (flag_r[F_OPEN]) begin
					state_nxt = ST_AWAIT;
				end else if (flag_r[F_TEMP_HOT]) begin
					state_nxt = ST_DONE;
				end else if (flag_r[F_SLOPE] && sec_r >= BLANK_S) begin
					state_nxt = ST_FINISH;
				end else if (sec_r >= bulk_span_s) begin
					state_nxt = ST_FINISH;
				end
			end
			ST_FINISH: begin
				if (flag_r[F_OPEN]) begin
					state_nxt = ST_AWAIT;
				end else if (flag_r[F_TEMP_HOT] || sec_r >= finish_span_s) begin
					state_nxt = ST_DONE;
				end
			end
			ST_DONE, ST_FAULT: begin
				if (flag_r[F_OPEN]) begin
					state_nxt = ST_AWAIT;
				end
			end
			ST_DRAIN: begin
				if (!drain_r) begin
					state_nxt = ST_AWAIT;
				end
			end
			default: state_nxt = ST_AWAIT;
		endcase
		// discharge overrides everything, suspend sends every state except drain to await
		if (drain_r) begin
			state_nxt = ST_DRAIN;
		end else if (!enable && state_r != ST_DRAIN) begin
			state_nxt = ST_AWAIT;
		end
	end

	// timers: seconds restart on every state change
	always_comb begin
		tick_cnt_nxt = sec_tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
		sec_nxt      = sec_r;
		if (state_nxt != state_r) begin
			sec_nxt      = 16'h0000;
			tick_cnt_nxt = 32'h0000_0000;
		end else if (sec_tick && sec_r != 16'hFFFF) begin
			sec_nxt = sec_r + 16'h0001;
		end
	end

	// events on entry into states
	always_comb begin
		ev           = '0;
		ev[EV_PHASE] = (state_nxt != state_r);
		ev[EV_FAULT] = (state_nxt == ST_FAULT) && (state_r != ST_FAULT);
		ev[EV_DONE]  = (state_nxt == ST_DONE) && (state_r != ST_DONE);
		ev[EV_DRAIN] = (state_nxt == ST_DRAIN) && (state_r != ST_DRAIN);
	end

	// register file next values, hardware set beats write-one clear
	always_comb begin
		ctrl_nxt = ctrl_r;
		imk_nxt  = imk_r;
		ist_nxt  = ist_r;
		if (wr_acc && wb_sel_i[0]) begin
			if (wb_adr_i == OFS_CTRL) begin
				ctrl_nxt = {31'h0000_0000, wb_dat_i[0]};
			end
			if (wb_adr_i == OFS_IRQ_MK) begin
				imk_nxt = wb_dat_i[EV_W-1:0];
			end
			if (wb_adr_i == OFS_IRQ_ST) begin
				ist_nxt = ist_r & ~wb_dat_i[EV_W-1:0];
			end
		end
		ist_nxt = ist_nxt | ev;
	end

	// bus answer one cycle after the request, dropped the cycle after
	always_comb begin
		ack_nxt  = wb_cyc_i && wb_stb_i && !ack_r;
		rdat_nxt = 32'h0000_0000;
		case (wb_adr_i)
			OFS_CTRL:   rdat_nxt = ctrl_r;
			OFS_STATUS: rdat_nxt = {27'h000_0000, drain_r, 1'b0, state_r};
			OFS_IRQ_ST: rdat_nxt = {28'h000_0000, ist_r};
			OFS_IRQ_MK: rdat_nxt = {28'h000_0000, imk_r};
			default:    rdat_nxt = 32'h0000_0000;  // unmapped reads zero
		endcase
	end

	// registering of all state
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			state_r    <= ST_AWAIT;
			tick_cnt_r <= 32'h0000_0000;
			sec_r      <= 16'h0000;
			drain_r    <= 1'b0;
			ctrl_r     <= CTRL_RST;
			ist_r      <= '0;
			imk_r      <= MASK_RST;
			ack_r      <= 1'b0;
			rdat_r     <= 32'h0000_0000;
		end else begin
			state_r    <= state_nxt;
			tick_cnt_r <= tick_cnt_nxt;
			sec_r      <= sec_nxt;
			drain_r    <= drain_nxt;
			ctrl_r     <= ctrl_nxt;
			ist_r      <= ist_nxt;
			imk_r      <= imk_nxt;
			ack_r      <= ack_nxt;
			rdat_r     <= rdat_nxt;
		end
	end

	// outputs
	logic charging;                            // a charge phase is active
	assign charging = (state_r == ST_COND) || (state_r == ST_BULK) ||
		(state_r == ST_FINISH);
	assign charge_drive_out_o     = 1'b0;
	// comparator style switches on the sense flag, linear keeps it enabled
	assign charge_drive_oe_o      = (state_r == ST_DRAIN) ||
		(charging && (lin_mode || flag_r[F_CUR_LOW]));
	assign amp_enable_o           = charging && lin_mode;
	assign hysteresis_en_o        = charging && !lin_mode;
	assign low_rate_o             = (state_r == ST_COND) || (state_r == ST_FINISH);
	assign charge_indicator_out_o = 1'b0;
	// fault also pulls low; blink shaping is outside
	assign charge_indicator_oe_o  = charging || (state_r == ST_FAULT);
	assign irq_o                  = |(ist_r & imk_r);
	assign wb_ack_o               = ack_r;
	assign wb_dat_o               = rdat_r;

	// checks: discharge has priority over every charge phase
	a_drain_entry: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		drain_r |=> state_r == ST_DRAIN) else $error("drain not entered");
	a_drain_drive: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_r == ST_DRAIN |-> charge_drive_oe_o && !charge_indicator_oe_o)
		else $error("drain drive wrong");
	// no charge function may stay active while the pack is drained
	a_drain_quiet: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_r == ST_DRAIN |-> !amp_enable_o && !hysteresis_en_o && !low_rate_o)
		else $error("charge function active in drain");
	a_latch_set: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		flag_r[F_DRAIN_SET] |=> drain_r) else $error("latch not set");
	a_latch_clear: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!flag_r[F_DRAIN_SET] && flag_r[F_DRAIN_REL] |=> !drain_r)
		else $error("latch not cleared");
	// sticky event must survive a clear written in the same cycle
	a_event_kept: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ev[EV_DRAIN] |=> ist_r[EV_DRAIN]) else $error("drain event lost");
	// sequence steps
	a_await_exit: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_r == ST_AWAIT && state_nxt == ST_COND |-> flag_r[F_TEMP_OK])
		else $error("left await out of window");
	a_blank_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_r == ST_BULK && sec_r < BLANK_S && sec_r < bulk_span_s
		|=> state_r != ST_FINISH) else $error("slope not blanked");
	a_slope_end: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_r == ST_BULK && flag_r[F_SLOPE] && sec_r >= BLANK_S && !flag_r[F_OPEN]
		&& !flag_r[F_TEMP_HOT] && !drain_r && enable
		|=> state_r == ST_FINISH) else $error("slope end missed");
	a_cond_tmo: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_r == ST_COND && sec_r >= COND_TMO_S && !flag_r[F_OPEN] && !drain_r && enable
		|=> state_r == ST_FAULT) else $error("conditioning timeout missed");
	a_low_rate: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		low_rate_o == (state_r inside {ST_COND, ST_FINISH}))
		else $error("setpoint select wrong");
	a_done_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_r == ST_DONE && !flag_r[F_OPEN] && !drain_r && enable
		|=> state_r == ST_DONE) else $error("done left early");
	// done and fault leave the regulating transistor off
	a_done_idle: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_r inside {ST_DONE, ST_FAULT} |-> !charge_drive_oe_o)
		else $error("drive active after charge end");
	// bus answer
	a_ack_pulse: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	// main scenarios
	c_full_cycle: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		state_r == ST_FINISH ##1 state_r == ST_DONE);
	c_slope_end: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		state_r == ST_BULK ##1 state_r == ST_FINISH);
	c_fault: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		state_r == ST_COND ##1 state_r == ST_FAULT);
	c_drain: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		state_r == ST_DRAIN ##1 state_r == ST_AWAIT);
endmodule // bcs_sequencer

/* File: src/bcs_pkg.sv */
// Purpose: shared constants and types of the battery charge sequencer
// Assumes: 20 MHz system clock, classic wishbone register access
// Notes:   times are kept in their printed unit, counts derived from them
package bcs_pkg;
	// clock and time base
	localparam int unsigned CLK_HZ          = 20_000_000;    // system clock rate
	localparam int unsigned SEC_CYCLES      = CLK_HZ * 1;    // cycles in one second
	localparam int unsigned SEC_PER_MIN     = 60;            // seconds in a minute
	localparam int unsigned BLANK_TENTH_MIN = 43;            // slope blanking, 4.3 min
	localparam int unsigned COND_TMO_MIN    = 30;            // conditioning timeout, min
	localparam int unsigned BULK_UNIT_MIN   = 30;            // bulk span step, 30 min
	localparam int unsigned BULK_MAX_MIN    = 360;           // bulk span ceiling, 6 h
	localparam int unsigned FILTER_S        = 4;             // insertion noise filter, s
	localparam logic [15:0] BLANK_S    = 16'(BLANK_TENTH_MIN * SEC_PER_MIN / 10);
	localparam logic [15:0] COND_TMO_S = 16'(COND_TMO_MIN * SEC_PER_MIN);
	localparam logic [15:0] BULK_UNIT_S = 16'(BULK_UNIT_MIN * SEC_PER_MIN);
	localparam logic [3:0]  SPAN_CODE_MAX = 4'(BULK_MAX_MIN / BULK_UNIT_MIN - 1);
	localparam logic [15:0] FILTER_SEC = 16'(FILTER_S);
	// register byte offsets
	localparam logic [3:0] OFS_CTRL   = 4'h0;  // control
	localparam logic [3:0] OFS_STATUS = 4'h4;  // live state
	localparam logic [3:0] OFS_IRQ_ST = 4'h8;  // sticky events, write one to clear
	localparam logic [3:0] OFS_IRQ_MK = 4'hC;  // event mask
	localparam logic [31:0] CTRL_RST  = 32'h0000_0001;  // charging enabled
	localparam logic [3:0]  MASK_RST  = 4'h0;            // all events masked
	// event bit positions
	localparam int unsigned EV_PHASE = 0;  // phase changed
	localparam int unsigned EV_FAULT = 1;  // fault entered
	localparam int unsigned EV_DONE  = 2;  // done entered
	localparam int unsigned EV_DRAIN = 3;  // discharge entered
	localparam int unsigned EV_W     = 4;
	// synchronised flag positions
	localparam int unsigned F_CELL_IN   = 0;   // cell voltage below detect level
	localparam int unsigned F_OPEN      = 1;   // cell voltage above open level
	localparam int unsigned F_ABOVE_LOW = 2;   // cell voltage above low_cell_level
	localparam int unsigned F_TEMP_OK   = 3;   // temperature inside 0..45 C
	localparam int unsigned F_TEMP_HOT  = 4;   // temperature above 50 C
	localparam int unsigned F_SLOPE     = 5;   // temperature slope above 0.5 C/min
	localparam int unsigned F_DRAIN_SET = 6;   // reverse drop at drain_detect_level
	localparam int unsigned F_DRAIN_REL = 7;   // charge drop at drain_release_level
	localparam int unsigned F_CUR_LOW   = 8;   // sense drop below active setpoint
	localparam int unsigned F_W         = 9;
	// charge sequence states
	typedef enum logic [2:0] {
		ST_AWAIT,
		ST_COND,
		ST_BULK,
		ST_FINISH,
		ST_DONE,
		ST_FAULT,
		ST_DRAIN
	} bcs_state_t;
endpackage

/* File: testbench/bcs_pack_model.sv */
// Purpose: behavioural cell pack with thermistor and sense resistor
// Assumes: bench sets cell voltage, temperature, slope and sense drop
// Notes:   ideal comparators; analog hysteresis is left out
`timescale 1ns/100ps
module bcs_pack_model (
	input  wire logic [15:0]       cell_mv_i,   // one-cell voltage, mV
	input  wire logic signed [7:0] temp_c_i,    // pack temperature, C
	input  wire logic [7:0]        slope_i,     // tenths of C per minute
	input  wire logic signed [7:0] sense_mv_i,  // sense drop, reverse positive
	input  wire logic              low_rate_i,  // low setpoint in use
	output logic                   cell_in_o,
	output logic                   open_o,
	output logic                   above_low_o,
	output logic                   temp_ok_o,
	output logic                   hot_o,
	output logic                   slope_o,
	output logic                   dset_o,
	output logic                   drel_o,
	output logic                   cur_low_o
);
	// divider already scales the stack to one cell
	assign cell_in_o   = cell_mv_i < 16'h060E;
	assign open_o      = cell_mv_i > 16'h0672;
	assign above_low_o = cell_mv_i > 16'h03E8;
	// thermistor window and limits
	assign temp_ok_o = temp_c_i >= 8'sh00 && temp_c_i <= 8'sh2D;
	assign hot_o     = temp_c_i > 8'sh32;
	assign slope_o   = slope_i > 8'h05;
	// sense resistor comparators, charge drop is negative
	assign dset_o    = sense_mv_i >= 8'sh0A;
	assign drel_o    = sense_mv_i <= -8'sh0A;
	assign cur_low_o = sense_mv_i > (low_rate_i ? -8'sh21 : -8'sh79);
endmodule // bcs_pack_model

/* File: testbench/testbench.sv */
// Purpose: self-checking bench of the charge sequencer
// Assumes: one simulated second is TICK clock cycles
// Notes:   state is observed through the status register
`timescale 1ns/100ps
module testbench;
	import bcs_pkg::*;
	localparam int TICK = 10;  // short second keeps the run small
	logic              clock_i, sys_rst_i, lin_mode, quarter;
	logic [3:0]        span_code, adr, sel;
	logic [15:0]       cell_mv;   // pack cell voltage
	logic signed [7:0] temp_c;    // pack temperature
	logic [7:0]        slope;     // temperature slope
	logic signed [7:0] sense_mv;  // sense drop
	logic              cyc, stb, we, ack, irq, drv_out, drv_oe, amp_en, hys_en;
	logic              low_rate, ind_out, ind_oe;
	logic [31:0]       wdat, rdat, q;
	logic f_in, f_open, f_low, f_tok, f_hot, f_slope, f_dset, f_drel, f_clow;
	int                errors, tests_run;
	logic [3:0]  ra[5] = '{OFS_CTRL, OFS_STATUS, OFS_IRQ_ST, OFS_IRQ_MK, 4'h1};
	logic [31:0] rv[5] = '{CTRL_RST, 32'h0, 32'h0, {28'h0, MASK_RST}, 32'h0};

	bcs_sequencer #(.TICK_CYCLES(TICK)) bcs_sequencer_inst (.clock_i(clock_i),
		.sys_rst_i(sys_rst_i), .cell_in_i(f_in), .cell_open_i(f_open),
		.cell_above_low_i(f_low), .temp_ok_i(f_tok), .temp_hot_i(f_hot),
		.slope_high_i(f_slope), .drain_set_i(f_dset), .drain_release_i(f_drel),
		.current_low_i(f_clow), .linear_mode_i(lin_mode), .quarter_variant_i(quarter),
		.timeout_select_i(span_code), .charge_drive_out_o(drv_out),
		.charge_drive_oe_o(drv_oe), .amp_enable_o(amp_en), .hysteresis_en_o(hys_en),
		.low_rate_o(low_rate), .charge_indicator_out_o(ind_out),
		.charge_indicator_oe_o(ind_oe), .irq_o(irq), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack));
	bcs_pack_model bcs_pack_model_inst (.cell_mv_i(cell_mv), .temp_c_i(temp_c),
		.slope_i(slope), .sense_mv_i(sense_mv), .low_rate_i(low_rate),
		.cell_in_o(f_in), .open_o(f_open), .above_low_o(f_low), .temp_ok_o(f_tok),
		.hot_o(f_hot), .slope_o(f_slope), .dset_o(f_dset), .drel_o(f_drel),
		.cur_low_o(f_clow));

	// 20 MHz clock
	always #25 clock_i = ~clock_i;

	task chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task chk_pin(input string name, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %b seen %b", name, exp, got);
		end
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// classic cycle: hold until ack, take data at that edge, then one idle cycle
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		sel <= 4'hF;
		adr <= a;
		wdat <= d;
		// no bound here: only the watchdog ends a wait that never gets an answer
		do begin
			@(posedge clock_i);
			n++;
		end while (ack !== 1'h1);
		r = rdat;
		chk_reg("ack latency", 32'h0000_0002, 32'(n));
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge clock_i);
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'h1, a, d, r);
	endtask
	task secs(input int n);
		repeat (n * TICK) @(posedge clock_i);
	endtask
	// expected bulk span in seconds: one span step per code value
	function automatic int bulk_secs(input int code);
		return (code + 1) * int'(BULK_UNIT_S);
	endfunction
	task chk_state(input bcs_state_t s);
		wb(1'h0, OFS_STATUS, 32'h0, q);
		chk_reg("state", 32'(s), {29'h0, q[2:0]});
	endtask
	// poll state under a bound of roughly max_s seconds
	task wait_state(input bcs_state_t s, input int max_s);
		int n;
		n = 0;
		do begin
			wb(1'h0, OFS_STATUS, 32'h0, q);
			n++;
		end while (q[2:0] !== s && n < max_s * TICK / 3);
		chk_reg("state", 32'(s), {29'h0, q[2:0]});
	endtask

	// watchdog, well beyond the expected run
	initial begin
		#(90_000 * 50);
		errors++;
		end_of_test();
	end

	initial begin
		{clock_i, cyc, stb, we, quarter, slope, sense_mv} = '0;
		{sys_rst_i, lin_mode} = 2'h3;
		{span_code, adr, wdat, sel} = {4'h0, 4'h0, 32'h0, 4'hF};
		cell_mv = 16'h0708;
		temp_c = 8'sh19;
		{errors, tests_run} = '0;
		void'($urandom(96));
		repeat (20) @(posedge clock_i);
		sys_rst_i <= 1'h0;
		@(posedge clock_i);
		for (int i = 0; i < 5; i++) begin
			wb(1'h0, ra[i], 32'h0, q);
			chk_reg("reset value", rv[i], q);
		end
		// pack inserted while too hot, then cooled
		temp_c <= 8'sh3C;
		cell_mv <= 16'(16'h02BC + $urandom_range(0, 250));
		secs(10);
		chk_state(ST_AWAIT);
		temp_c <= 8'sh19;
		wait_state(ST_COND, 4);
		chk_pin("low rate", 1'h1, low_rate);
		chk_pin("amp", 1'h1, amp_en);
		chk_pin("indicator", 1'h1, ind_oe);
		chk_pin("indicator level", 1'h0, ind_out);
		cell_mv <= 16'h0514;
		wait_state(ST_BULK, 4);
		chk_pin("low rate", 1'h0, low_rate);
		// slope present from the start must wait out the blanking
		slope <= 8'(6 + $urandom_range(0, 20));
		secs(int'(BLANK_S) - 8);
		chk_state(ST_BULK);
		wait_state(ST_FINISH, 16);
		secs(bulk_secs(0) / 2 - 8);
		chk_state(ST_FINISH);
		wait_state(ST_DONE, 16);
		secs(50);
		chk_state(ST_DONE);
		chk_pin("drive", 1'h0, drv_oe);
		chk_pin("indicator", 1'h0, ind_oe);
		// masked events stay quiet, then discharge raises the line
		wb(1'h0, OFS_IRQ_ST, 32'h0, q);
		chk_reg("irq status", 32'h0000_0005, q);
		chk_pin("irq", 1'h0, irq);
		wr(OFS_IRQ_MK, 32'h0000_0008);
		sense_mv <= 8'(8'sh0A + $urandom_range(0, 5));
		wait_state(ST_DRAIN, 4);
		chk_pin("drive", 1'h1, drv_oe);
		chk_pin("drive level", 1'h0, drv_out);
		chk_pin("indicator", 1'h0, ind_oe);
		chk_pin("irq", 1'h1, irq);
		wr(OFS_IRQ_ST, 32'h0000_000F);
		wr(OFS_STATUS, 32'h0000_0007);
		@(posedge clock_i);
		chk_pin("irq", 1'h0, irq);
		chk_state(ST_DRAIN);
		temp_c <= 8'sh3C;
		sense_mv <= -8'sh0C;
		wait_state(ST_AWAIT, 4);
		// comparator style, deep cell that never recovers
		sense_mv <= -8'sh14;
		lin_mode <= 1'h0;
		temp_c <= 8'sh19;
		cell_mv <= 16'(16'h01F4 + $urandom_range(0, 400));
		wait_state(ST_COND, 4);
		chk_pin("hysteresis", 1'h1, hys_en);
		chk_pin("amp", 1'h0, amp_en);
		chk_pin("drive", 1'h1, drv_oe);
		sense_mv <= -8'sh28;
		repeat (5) @(posedge clock_i);
		chk_pin("drive", 1'h0, drv_oe);
		secs(int'(COND_TMO_S) - 10);
		chk_state(ST_COND);
		wait_state(ST_FAULT, 16);
		cell_mv <= 16'h0708;
		wait_state(ST_AWAIT, 8);
		// backup timer, alternate finishing ratio
		lin_mode <= 1'h1;
		quarter <= 1'h1;
		slope <= 8'h00;
		cell_mv <= 16'h0514;
		wait_state(ST_BULK, 8);
		secs(bulk_secs(0) - 8);
		chk_state(ST_BULK);
		wait_state(ST_FINISH, 16);
		secs(bulk_secs(0) / 4 - 8);
		chk_state(ST_FINISH);
		wait_state(ST_DONE, 16);
		cell_mv <= 16'h0708;
		wait_state(ST_AWAIT, 4);
		// removal ends bulk charge, then the pack is refitted
		cell_mv <= 16'h0514;
		wait_state(ST_BULK, 8);
		cell_mv <= 16'h0708;
		wait_state(ST_AWAIT, 4);
		cell_mv <= 16'h0514;
		wait_state(ST_BULK, 8);
		// software suspend from bulk, then a fresh cycle with the pack still fitted
		wr(OFS_CTRL, 32'h0000_0000);
		wait_state(ST_AWAIT, 4);
		chk_pin("indicator", 1'h0, ind_oe);
		wb(1'h0, OFS_CTRL, 32'h0, q);
		chk_reg("ctrl", 32'h0000_0000, q);
		wr(OFS_CTRL, 32'h0000_0001);
		wait_state(ST_BULK, 8);
		temp_c <= 8'sh37;
		wait_state(ST_DONE, 4);
		end_of_test();
	end
endmodule // testbench
